/* shared/hpidc_regs.vh */
// register offsets, field positions and reset values of the hub id and configuration bank
`ifndef HPIDC_REGS_VH
`define HPIDC_REGS_VH
`define HPIDC_OFF_PROD_LOW      8'h03
`define HPIDC_OFF_PROD_HIGH     8'h04
`define HPIDC_OFF_DEV_CFG       8'h05
`define HPIDC_RST_DEV_CFG       8'h10
`define HPIDC_BIT_STR_WE        7
`define HPIDC_BIT_SER_WE        6
`define HPIDC_BIT_LPM_OFF       5
`define HPIDC_BIT_RSVD_ONE      4
`define HPIDC_BIT_GANGED        3
`define HPIDC_BIT_PWR_RPT_OFF   2
`define HPIDC_BIT_TMO_OVR       1
`define HPIDC_BIT_RSVD_ZERO     0
`define HPIDC_CFG_WR_MASK       8'hee
`define HPIDC_USB2_PID_XOR      8'h02
`define HPIDC_TMO_MAX           8'hff
`define HPIDC_TMO_ZERO          8'h00
`define HPIDC_BYTE_ZERO         8'h00
`define HPIDC_BYTE_ONES         8'hff
`endif

/* hdl/hpidc_id_select.v */
// priority selection of one identifier byte among loaded, otp and default values
`timescale 1ns/100ps
`include "hpidc_regs.vh"
module hpidc_id_select #(
    parameter [7:0] DEFAULT_VALUE = 8'h00
) (
    input  wire       ids_loaded_zero_in,
    input  wire [7:0] loaded_byte_in,
    input  wire       otp_ids_zero_in,
    input  wire [7:0] otp_byte_in,
    output wire [7:0] chosen_byte_out
);
    // zero test is over the whole vendor/product pair, not this byte alone
    assign chosen_byte_out = !ids_loaded_zero_in ? loaded_byte_in :
                             !otp_ids_zero_in    ? otp_byte_in :
                             DEFAULT_VALUE;
endmodule

/* hdl/hpidc_config_bank.v */
// hub product id and device configuration register bank
`timescale 1ns/100ps
`include "hpidc_regs.vh"
module hpidc_config_bank #(
    parameter       PORTS            = 4,
    parameter [7:0] PROD_LOW_DEFAULT = 8'h5a, // arbitrary identity value
    parameter [7:0] PROD_HIGH_DEFAULT = 8'ha5 // arbitrary identity value
) (
    input  wire             sys_clk_in,
    input  wire             resetn_in,
    input  wire             smbus_mode_in,
    input  wire             wr_strobe_in,
    input  wire             wr_from_eeprom_in,
    input  wire [7:0]       wr_addr_in,
    input  wire [7:0]       wr_data_in,
    input  wire [7:0]       rd_addr_in,
    output reg  [7:0]       rd_data_out,
    input  wire [15:0]      vendor_ident_in,
    input  wire [15:0]      otp_vendor_ident_in,
    input  wire [15:0]      otp_prod_ident_in,
    output reg  [15:0]      prod_ident_ss_out,
    output reg  [15:0]      prod_ident_usb2_out,
    output wire             string_write_enable_out,
    output wire             serial_string_write_enable_out,
    input  wire             lpm_request_in,
    input  wire             force_accept_lmp_in,
    input  wire             upstream_disconnect_in,
    output wire             lpm_allowed_out,
    input  wire [PORTS-1:0] port_power_request_in,
    output reg  [PORTS-1:0] port_power_control_pins_out,
    output wire             power_status_report_on_out,
    input  wire [7:0]       host_timeout_in,
    output reg  [7:0]       applied_timeout_out
);
    reg  [7:0]  prod_low_reg;
    reg  [7:0]  prod_high_reg;
    reg  [7:0]  cfg_reg;
    reg         force_lpm_reg;
    wire [7:0]  cfg_view;
    wire [7:0]  sel_low;
    wire [7:0]  sel_high;
    wire        loaded_zero;
    wire        otp_zero;
    wire        cfg_wr_ok;
    wire        eeprom_load_ok;
    wire        host_write_ok;
    wire        loaded_pid_zero;
    wire        loaded_vid_zero;
    wire        otp_pid_zero;
    wire        otp_vid_zero;
    wire        gang_on;
    wire [PORTS-1:0] pins_next;
    reg  [7:0]  prod_low_next;
    reg  [7:0]  prod_high_next;
    reg  [7:0]  cfg_next;
    reg  [7:0]  rd_data_next;
    reg  [7:0]  timeout_next;
    reg         force_lpm_next;
    genvar      g;

    // eeprom loads only count in i2c mode, host writes only in smbus mode
    assign eeprom_load_ok = wr_from_eeprom_in && !smbus_mode_in;
    assign host_write_ok  = !wr_from_eeprom_in && smbus_mode_in;
    assign cfg_wr_ok      = wr_strobe_in && (eeprom_load_ok || host_write_ok);

    // unmatched offsets and refused writes keep the stored contents
    always @* begin
        prod_low_next  = prod_low_reg;
        prod_high_next = prod_high_reg;
        cfg_next       = cfg_reg;
        if (cfg_wr_ok) begin
            case (wr_addr_in)
                `HPIDC_OFF_PROD_LOW: begin
                    prod_low_next = wr_data_in;
                end
                `HPIDC_OFF_PROD_HIGH: begin
                    prod_high_next = wr_data_in;
                end
                `HPIDC_OFF_DEV_CFG: begin
                    // reserved bits keep fixed values whatever is written
                    cfg_next = (wr_data_in & `HPIDC_CFG_WR_MASK)
                               | `HPIDC_RST_DEV_CFG;
                end
                default: begin
                    cfg_next = cfg_reg;
                end
            endcase
        end
    end

    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prod_low_reg  <= `HPIDC_BYTE_ZERO;
            prod_high_reg <= `HPIDC_BYTE_ZERO;
        end else begin
            prod_low_reg  <= prod_low_next;
            prod_high_reg <= prod_high_next;
        end
    end

    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_reg <= `HPIDC_RST_DEV_CFG;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // reserved bit 4 forced high and bit 0 forced low on every read
    assign cfg_view = (cfg_reg | (8'h01 << `HPIDC_BIT_RSVD_ONE))
                      & ~(8'h01 << `HPIDC_BIT_RSVD_ZERO);

    assign loaded_pid_zero = ({prod_high_reg, prod_low_reg} == 16'h0000);
    assign loaded_vid_zero = (vendor_ident_in == 16'h0000);
    // zero test spans the whole pid/vid pair so a partial load still wins
    assign loaded_zero     = loaded_pid_zero && loaded_vid_zero;
    assign otp_pid_zero    = (otp_prod_ident_in == 16'h0000);
    assign otp_vid_zero    = (otp_vendor_ident_in == 16'h0000);
    assign otp_zero        = otp_pid_zero && otp_vid_zero;

    hpidc_id_select #(
        .DEFAULT_VALUE (PROD_LOW_DEFAULT)
    ) u_sel_low (
        .ids_loaded_zero_in (loaded_zero),
        .loaded_byte_in     (prod_low_reg),
        .otp_ids_zero_in    (otp_zero),
        .otp_byte_in        (otp_prod_ident_in[7:0]),
        .chosen_byte_out    (sel_low)
    );

    hpidc_id_select #(
        .DEFAULT_VALUE (PROD_HIGH_DEFAULT)
    ) u_sel_high (
        .ids_loaded_zero_in (loaded_zero),
        .loaded_byte_in     (prod_high_reg),
        .otp_ids_zero_in    (otp_zero),
        .otp_byte_in        (otp_prod_ident_in[15:8]),
        .chosen_byte_out    (sel_high)
    );

    // read data is registered so the reader sees a clean byte one edge after the offset
    always @* begin
        case (rd_addr_in)
            `HPIDC_OFF_PROD_LOW: begin
                rd_data_next = sel_low;
            end
            `HPIDC_OFF_PROD_HIGH: begin
                rd_data_next = sel_high;
            end
            `HPIDC_OFF_DEV_CFG: begin
                rd_data_next = cfg_view;
            end
            default: begin
                // unmapped offsets read as zero rather than echoing a neighbour
                rd_data_next = `HPIDC_BYTE_ZERO;
            end
        endcase
    end

    // a zero request must stay zero so the override never wakes a disabled timer
    always @* begin
        if (cfg_reg[`HPIDC_BIT_TMO_OVR] && (host_timeout_in != `HPIDC_TMO_ZERO)) begin
            timeout_next = `HPIDC_TMO_MAX;
        end else begin
            timeout_next = host_timeout_in;
        end
    end

    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_data_out         <= `HPIDC_BYTE_ZERO;
            prod_ident_ss_out   <= 16'h0000;
            prod_ident_usb2_out <= 16'h0000;
        end else begin
            rd_data_out         <= rd_data_next;
            prod_ident_ss_out   <= {sel_high, sel_low};
            prod_ident_usb2_out <= {sel_high, sel_low ^ `HPIDC_USB2_PID_XOR};
        end
    end

    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            applied_timeout_out <= `HPIDC_TMO_ZERO;
        end else begin
            applied_timeout_out <= timeout_next;
        end
    end

    assign string_write_enable_out        = cfg_reg[`HPIDC_BIT_STR_WE];
    assign serial_string_write_enable_out = cfg_reg[`HPIDC_BIT_SER_WE];

    // sticky until reset or upstream disconnect; set wins over the clear
    always @* begin
        if (force_accept_lmp_in) begin
            force_lpm_next = 1'b1;
        end else if (upstream_disconnect_in) begin
            force_lpm_next = 1'b0;
        end else begin
            force_lpm_next = force_lpm_reg;
        end
    end

    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            force_lpm_reg <= 1'b0;
        end else begin
            force_lpm_reg <= force_lpm_next;
        end
    end

    assign lpm_allowed_out = lpm_request_in &&
        (!cfg_reg[`HPIDC_BIT_LPM_OFF] || force_lpm_reg);

    assign power_status_report_on_out = !cfg_reg[`HPIDC_BIT_PWR_RPT_OFF];

    // ganging only holds while power status reporting is on
    assign gang_on = cfg_reg[`HPIDC_BIT_GANGED]
                     && !cfg_reg[`HPIDC_BIT_PWR_RPT_OFF];

    generate
        for (g = 0; g < PORTS; g = g + 1) begin : gen_port_pwr
            assign pins_next[g] = gang_on ? port_power_request_in[0]
                                          : port_power_request_in[g];
        end
    endgenerate

    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            port_power_control_pins_out <= {PORTS{1'b0}};
        end else begin
            port_power_control_pins_out <= pins_next;
        end
    end
endmodule

/* sim/hpidc_host_model.sv */
// eeprom loader or smbus host model on the bank write port
`timescale 1ns/100ps
module hpidc_host_model (
    input  wire       sys_clk_in,
    output reg        wr_strobe_out,
    output reg        wr_from_eeprom_out,
    output reg  [7:0] wr_addr_out,
    output reg  [7:0] wr_data_out
);
    initial {wr_from_eeprom_out, wr_addr_out, wr_data_out, wr_strobe_out} = 18'h0;
    // one write per call from eeprom (src 1) or smbus host (src 0)
    task write(input logic src, input logic [7:0] a, input logic [7:0] d);
        {wr_from_eeprom_out, wr_addr_out, wr_data_out, wr_strobe_out} = {src, a, d, 1'b1};
        @(posedge sys_clk_in);
        // released lines invert so stale data never looks valid
        #1 {wr_addr_out, wr_data_out, wr_strobe_out} = {~a, ~d, 1'b0};
        // an idle edge keeps back-to-back calls from retouching the strobe in one step
        @(posedge sys_clk_in);
        #1;
    endtask
endmodule

/* sim/hpidc_config_bank_props.sv */
// port assertions of the configuration bank
`timescale 1ns/100ps
module hpidc_config_bank_props #(parameter PORTS = 4) (
    input wire             sys_clk_in,
    input wire             resetn_in,
    input wire [7:0]       rd_addr_in,
    input wire [7:0]       rd_data_out,
    input wire             string_write_enable_out,
    input wire             lpm_request_in,
    input wire             force_accept_lmp_in,
    input wire             lpm_allowed_out,
    input wire [PORTS-1:0] port_power_request_in,
    input wire [PORTS-1:0] port_power_control_pins_out,
    input wire             power_status_report_on_out,
    input wire [7:0]       host_timeout_in,
    input wire [7:0]       applied_timeout_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    reg  [PORTS-1:0] req_q;
    wire             c = rd_addr_in == 8'h05;
    // pins are registered, so compare against last cycle's requests
    wire [PORTS-1:0] gang = rd_data_out[3] ? {PORTS{req_q[0]}} : req_q;
    always @(posedge sys_clk_in) req_q <= port_power_request_in;
    a_rsvd_bits: assert property (c |=> rd_data_out[4] && !rd_data_out[0])
        else $error("reserved bits wrong");
    a_string_gate: assert property (c |=> rd_data_out[7] == $past(string_write_enable_out))
        else $error("string enable wrong");
    a_lpm_block: assert property (c && lpm_request_in |=> rd_data_out[5] || $past(lpm_allowed_out))
        else $error("lpm refused");
    a_force_keep: assert property (force_accept_lmp_in |=> lpm_allowed_out == lpm_request_in)
        else $error("force not kept");
    a_port_gang: assert property (c |=> rd_data_out[2] || port_power_control_pins_out == gang)
        else $error("port pins wrong");
    a_report_off: assert property (c |=> rd_data_out[2] != $past(power_status_report_on_out))
        else $error("report wrong");
    a_tmo_max: assert property (c && host_timeout_in != 8'h00 |=> !rd_data_out[1] || applied_timeout_out == 8'hff)
        else $error("timeout not max");
    a_tmo_zero: assert property (host_timeout_in == 8'h00 |=> applied_timeout_out == 8'h00)
        else $error("timeout not zero");
    c_force: cover property (force_accept_lmp_in);
    c_gang: cover property (c && rd_data_out[3]);
    c_tmo: cover property (applied_timeout_out == 8'hff);
endmodule
bind hpidc_config_bank hpidc_config_bank_props #(.PORTS(PORTS)) i_hpidc_config_bank_props (.*);

/* sim/hpidc_config_bank_test.sv */
// self-checking bench of the configuration bank
`timescale 1ns/100ps
module hpidc_config_bank_test;
    logic sys_clk_in, resetn_in, smbus_mode_in, wr_strobe_in, wr_from_eeprom_in, lpm_request_in;
    logic force_accept_lmp_in, upstream_disconnect_in, lpm_allowed_out, string_write_enable_out;
    logic serial_string_write_enable_out, power_status_report_on_out;
    logic [7:0] wr_addr_in, wr_data_in, rd_addr_in, rd_data_out, host_timeout_in, applied_timeout_out;
    logic [15:0] vendor_ident_in, otp_vendor_ident_in, otp_prod_ident_in, prod_ident_ss_out;
    logic [15:0] prod_ident_usb2_out;
    logic [3:0] port_power_request_in, port_power_control_pins_out;
    wire [2:0] en = {string_write_enable_out, serial_string_write_enable_out, power_status_report_on_out};
    int fails = 0, tests_run = 0;
    // smbus mode, eeprom source, written byte, byte read back
    logic [17:0] rows [4] = '{18'h2fffe, 18'h10010, 18'h0ff10, 18'h3aa10};
    hpidc_config_bank i_hpidc_config_bank (.*);
    hpidc_host_model i_hpidc_host_model (.sys_clk_in(sys_clk_in), .wr_strobe_out(wr_strobe_in),
        .wr_from_eeprom_out(wr_from_eeprom_in), .wr_addr_out(wr_addr_in), .wr_data_out(wr_data_in));
    task chk(string n, logic [15:0] e, logic [15:0] g);
        tests_run++;
        fails += (e !== g);
        if (e !== g) $display("mismatch %s expected %h seen %h", n, e, g);
    endtask
    task cyc;
        @(posedge sys_clk_in);
        #1;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        sys_clk_in = 0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        #20us;
        fails++;
        finish_test;
    end
    initial begin
        {resetn_in, smbus_mode_in, lpm_request_in, force_accept_lmp_in, upstream_disconnect_in} = 5'h0;
        {vendor_ident_in, otp_vendor_ident_in, otp_prod_ident_in} = 48'h0;
        {host_timeout_in, rd_addr_in, port_power_request_in} = 20'h00050;
        repeat (5) cyc;
        resetn_in = 1;
        cyc;
        chk("cfg", 8'h10, rd_data_out);
        chk("usb2", 16'ha558, prod_ident_usb2_out);
        foreach (rows[i]) begin
            smbus_mode_in = rows[i][17];
            i_hpidc_host_model.write(rows[i][16], 8'h05, rows[i][15:8]);
            cyc;
            chk("cfg", rows[i][7:0], rd_data_out);
            chk("en", {rows[i][7:6], !rows[i][2]}, en);
        end
        $display("test of config writes done");
        {smbus_mode_in, otp_vendor_ident_in, otp_prod_ident_in} = 33'h0_0001_1234;
        cyc;
        chk("pid", 16'h1234, prod_ident_ss_out);
        vendor_ident_in = 16'h0002;
        i_hpidc_host_model.write(1, 8'h03, 8'h78);
        i_hpidc_host_model.write(1, 8'h04, 8'h56);
        cyc;
        chk("usb2", 16'h567a, prod_ident_usb2_out);
        $display("test of ident done");
        smbus_mode_in = 1;
        i_hpidc_host_model.write(0, 8'h05, 8'h2a);
        {lpm_request_in, port_power_request_in, host_timeout_in} = 13'h1105;
        cyc;
        chk("lpm", 0, lpm_allowed_out);
        chk("pins", 4'hf, port_power_control_pins_out);
        chk("tmo", 8'hff, applied_timeout_out);
        {force_accept_lmp_in, host_timeout_in} = 9'h100;
        cyc;
        {force_accept_lmp_in, upstream_disconnect_in} = 2'b01;
        chk("lpm", 1, lpm_allowed_out);
        chk("tmo", 0, applied_timeout_out);
        cyc;
        {upstream_disconnect_in, rd_addr_in, port_power_request_in} = 13'h0072;
        chk("lpm", 0, lpm_allowed_out);
        {force_accept_lmp_in, upstream_disconnect_in} = 2'b11;
        cyc;
        {force_accept_lmp_in, upstream_disconnect_in} = 2'b01;
        chk("lpm", 1, lpm_allowed_out);
        cyc;
        upstream_disconnect_in = 0;
        chk("lpm", 0, lpm_allowed_out);
        i_hpidc_host_model.write(0, 8'h05, 8'h00);
        host_timeout_in = 8'h05;
        cyc;
        chk("pins", 4'h2, port_power_control_pins_out);
        chk("unmapped", 0, rd_data_out);
        chk("tmo", 8'h05, applied_timeout_out);
        $display("test of power control done");
        finish_test;
    end
endmodule
